//--- sys_cfg_pkg.sv
// Constants shared by the configuration and chip-select logic.
// Assumes an 8-bit CPU I/O path and a 20-bit memory address.

package sys_cfg_pkg;

   // ----------------------------------------
   // Register map (low I/O address byte)
   // ----------------------------------------
   localparam logic [7:0] REG_RAM_UB  = 8'hE6;
   localparam logic [7:0] REG_RAM_LB  = 8'hE7;
   localparam logic [7:0] REG_ROM_UB  = 8'hE8;
   localparam logic [7:0] REG_SYS_CFG = 8'hEF;

   localparam logic [7:0] BOUND_RESET = 8'hFF;
   localparam logic [7:0] CFG_RESET   = 8'h00;
   localparam logic [7:0] READ_NONE   = 8'h00;

   // ----------------------------------------
   // Configuration bit positions
   // ----------------------------------------
   localparam int CFG_PORTC   = 7;
   localparam int CFG_PB75    = 6;
   localparam int CFG_PB40    = 5;
   localparam int CFG_EMU     = 4;
   localparam int CFG_ROM_DIS = 3;
   localparam int CFG_TRI_HI  = 2;
   localparam int CFG_HOST    = 1;
   localparam int CFG_CHAIN   = 0;

   // Compared address field
   localparam int PAGE_HI = 19;
   localparam int PAGE_LO = 12;

   // Triple-pin selections
   localparam logic [1:0] TRI_CHAN_B = 2'h2;
   localparam logic [1:0] TRI_HOST   = 2'h3;

   typedef enum logic [1:0] {
      DIR_Z   = 2'h0,
      DIR_IN  = 2'h1,
      DIR_OUT = 2'h2
   } bus_dir_t;

endpackage

//--- chip_select_decode.sv
// Page comparators for the ROM and RAM chip selects.
// Assumes the caller registers the selects and gives the core address.
`timescale 1ns/1ns

module chip_select_decode (
   // Cycle
   input  wire logic [7:0] page,
   input  wire logic       mem_cycle,
   input  wire logic       rom_disable,
   // Bounds
   input  wire logic [7:0] rom_ub,
   input  wire logic [7:0] ram_ub,
   input  wire logic [7:0] ram_lb,
   // Selects, active high
   output logic            rom_sel,
   output logic            ram_sel
);
   logic rom_hit;
   logic ram_hit;

   always_comb begin
      rom_hit = (page <= rom_ub) && !rom_disable;
      ram_hit = (page <= ram_ub) && (page >= ram_lb);
      rom_sel = mem_cycle && rom_hit;
      ram_sel = mem_cycle && ram_hit && !rom_hit;
   end

endmodule

//--- bus_dir_decode.sv
// Data bus direction for each transaction type.
// Assumes one-hot-ish cycle strobes from the CPU core, same clock.
`timescale 1ns/1ns

module bus_dir_decode
   import sys_cfg_pkg::*;
(
   // Transaction
   input  wire logic   bus_master,
   input  wire logic   io_req,
   input  wire logic   mem_req,
   input  wire logic   rd_req,
   input  wire logic   wr_req,
   input  wire logic   ack_cycle,
   input  wire logic   refresh,
   input  wire logic   onchip_sel,
   input  wire logic   chain_in,
   input  wire logic   emu,
   // Result
   output bus_dir_t    dir
);
   always_comb begin
      dir = DIR_Z;
      if (refresh) begin
         dir = DIR_Z;
      end else if (bus_master) begin
         if (ack_cycle) begin
            if (!chain_in) dir = DIR_IN;
            else if (emu) dir = DIR_OUT;
         end else if (io_req && wr_req) begin
            dir = DIR_OUT;
         end else if (io_req && rd_req) begin
            if (!onchip_sel) dir = DIR_IN;
            else if (emu) dir = DIR_OUT;
         end else if (mem_req && wr_req) begin
            dir = DIR_OUT;
         end else if (mem_req && rd_req) begin
            dir = DIR_IN;
         end
      end else begin
         if (ack_cycle) begin
            dir = onchip_sel ? DIR_OUT : DIR_IN;
         end else if (io_req && wr_req) begin
            dir = onchip_sel ? DIR_IN : DIR_Z;
         end else if (io_req && rd_req) begin
            dir = onchip_sel ? DIR_OUT : DIR_Z;
         end else if (mem_req && rd_req) begin
            dir = DIR_IN;
         end
      end
   end

endmodule

//--- sys_config_chip_select.sv
// System configuration register, pin steering, daisy chain and
// memory chip selects. Assumes CPU strobes on clk; chain input is a pin.
`timescale 1ns/1ns

module sys_config_chip_select (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // CPU core cycle
   input  wire logic [19:0] cpu_addr,
   input  wire logic [7:0]  cpu_wdata,
   input  wire logic [7:0]  vector_data,
   input  wire logic        io_req,
   input  wire logic        mem_req,
   input  wire logic        rd_req,
   input  wire logic        wr_req,
   input  wire logic        ack_cycle,
   input  wire logic        refresh,
   input  wire logic        bus_master,
   input  wire logic        onchip_sel,
   output logic [7:0]       rdata,
   output logic             rd_hit,
   // External data bus
   output logic [7:0]       dbus_out,
   output logic             dbus_oe_n,
   output logic             dbus_capture,
   // Chip selects
   output logic             rom_chip_select_n,
   output logic             ram_chip_select_n,
   // Interrupts and daisy chain
   input  wire logic        chain_enable_in,
   input  wire logic        serial_int_req,
   input  wire logic        host_int_req,
   input  wire logic        serial_int_pend,
   input  wire logic        host_int_pend,
   output logic             irq0_n,
   output logic             serial_chain_in,
   output logic             host_chain_in,
   // Mode outputs
   output logic             emulator_direction_flag,
   output logic             chan_b_outputs_enable,
   output logic             parallel_port_enable,
   output logic             host_emul_enable,
   // Port C pins and their sources
   input  wire logic [7:0]  port_c_out,
   input  wire logic [7:0]  port_c_oe_n,
   input  wire logic [7:0]  chan_a_out,
   input  wire logic [7:0]  chan_a_oe_n,
   output logic [7:0]       pc_pin_out,
   output logic [7:0]       pc_pin_oe_n,
   // Port B pins and their sources
   input  wire logic [7:0]  port_b_out,
   input  wire logic [7:0]  port_b_oe_n,
   input  wire logic        async1_tx,
   input  wire logic [4:0]  async0_out,
   input  wire logic [4:0]  async0_oe_n,
   output logic [7:0]       pb_pin_out,
   output logic [7:0]       pb_pin_oe_n,
   // Triple-shared pins and their sources
   input  wire logic        dma1_end_n,
   input  wire logic        clocked_serial_tx,
   input  wire logic        clocked_serial_clock,
   input  wire logic        clocked_serial_clock_oe_n,
   input  wire logic        chan_b_request_to_send_n,
   input  wire logic        chan_b_terminal_ready_req_n,
   input  wire logic        chan_b_wait_req_n,
   input  wire logic        host_rx_ready_n,
   input  wire logic        host_tx_ready_n,
   input  wire logic        host_interrupt,
   output logic [2:0]       tri_pin_out,
   output logic [2:0]       tri_pin_oe_n
);
   import sys_cfg_pkg::*;

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   logic [7:0] ram_upper_bound_reg, ram_upper_bound_next;
   logic [7:0] ram_lower_bound_reg, ram_lower_bound_next;
   logic [7:0] rom_upper_bound_reg, rom_upper_bound_next;
   logic [7:0] sys_cfg_reg,         sys_cfg_next;
   logic [7:0] rdata_reg,           rdata_next;
   logic       rd_hit_reg,          rd_hit_next;
   logic       io_wr;
   logic       io_rd;

   // Only the low address byte decodes; page bits alias
   always_comb begin
      io_wr = io_req && wr_req && !ack_cycle;
      io_rd = io_req && rd_req && !ack_cycle;
      ram_upper_bound_next = ram_upper_bound_reg;
      ram_lower_bound_next = ram_lower_bound_reg;
      rom_upper_bound_next = rom_upper_bound_reg;
      sys_cfg_next         = sys_cfg_reg;
      rdata_next           = READ_NONE;
      rd_hit_next          = 1'b0;
      if (io_wr) begin
         unique case (cpu_addr[7:0])
            REG_RAM_UB:  ram_upper_bound_next = cpu_wdata;
            REG_RAM_LB:  ram_lower_bound_next = cpu_wdata;
            REG_ROM_UB:  rom_upper_bound_next = cpu_wdata;
            REG_SYS_CFG: sys_cfg_next = cpu_wdata;
            default: ;
         endcase
      end
      if (io_rd) begin
         rd_hit_next = 1'b1;
         unique case (cpu_addr[7:0])
            REG_RAM_UB:  rdata_next = ram_upper_bound_reg;
            REG_RAM_LB:  rdata_next = ram_lower_bound_reg;
            REG_ROM_UB:  rdata_next = rom_upper_bound_reg;
            REG_SYS_CFG: rdata_next = sys_cfg_reg;
            default:     rd_hit_next = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ram_upper_bound_reg <= BOUND_RESET;
         ram_lower_bound_reg <= BOUND_RESET;
         rom_upper_bound_reg <= BOUND_RESET;
         sys_cfg_reg         <= CFG_RESET;
         rdata_reg           <= READ_NONE;
         rd_hit_reg          <= 1'b0;
      end else begin
         ram_upper_bound_reg <= ram_upper_bound_next;
         ram_lower_bound_reg <= ram_lower_bound_next;
         rom_upper_bound_reg <= rom_upper_bound_next;
         sys_cfg_reg         <= sys_cfg_next;
         rdata_reg           <= rdata_next;
         rd_hit_reg          <= rd_hit_next;
      end
   end

   assign rdata  = rdata_reg;
   assign rd_hit = rd_hit_reg;

   // ----------------------------------------
   // Chain input synchroniser
   // ----------------------------------------
   logic chain_meta_reg;
   logic chain_sync_reg;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         chain_meta_reg <= 1'b0;
         chain_sync_reg <= 1'b0;
      end else begin
         chain_meta_reg <= chain_enable_in;
         chain_sync_reg <= chain_meta_reg;
      end
   end

   // ----------------------------------------
   // Decoders
   // ----------------------------------------
   logic     rom_sel;
   logic     ram_sel;
   logic     mem_cycle;
   bus_dir_t dir;

   // Refresh and acknowledge never select memory
   assign mem_cycle = mem_req && !refresh && !ack_cycle;

   // Core address bit 19 is used, ahead of the timer output mux
   chip_select_decode u_cs (
      .page        (cpu_addr[PAGE_HI:PAGE_LO]),
      .mem_cycle   (mem_cycle),
      .rom_disable (sys_cfg_reg[CFG_ROM_DIS]),
      .rom_ub      (rom_upper_bound_reg),
      .ram_ub      (ram_upper_bound_reg),
      .ram_lb      (ram_lower_bound_reg),
      .rom_sel     (rom_sel),
      .ram_sel     (ram_sel)
   );

   bus_dir_decode u_dir (
      .bus_master (bus_master),
      .io_req     (io_req),
      .mem_req    (mem_req),
      .rd_req     (rd_req),
      .wr_req     (wr_req),
      .ack_cycle  (ack_cycle),
      .refresh    (refresh),
      .onchip_sel (onchip_sel),
      .chain_in   (chain_sync_reg),
      .emu        (sys_cfg_reg[CFG_EMU]),
      .dir        (dir)
   );

   // ----------------------------------------
   // Bus, selects and chain outputs
   // ----------------------------------------
   logic [7:0] dbus_reg,    dbus_next;
   logic       dbus_oe_n_reg, dbus_oe_n_next;
   logic       capture_reg, capture_next;
   logic       rom_cs_n_reg, rom_cs_n_next;
   logic       ram_cs_n_reg, ram_cs_n_next;
   logic       irq0_n_reg,  irq0_n_next;
   logic       serial_chain_reg, serial_chain_next;
   logic       host_chain_reg,   host_chain_next;
   logic [7:0] onchip_rd;

   always_comb begin
      onchip_rd = READ_NONE;
      unique case (cpu_addr[7:0])
         REG_RAM_UB:  onchip_rd = ram_upper_bound_reg;
         REG_RAM_LB:  onchip_rd = ram_lower_bound_reg;
         REG_ROM_UB:  onchip_rd = rom_upper_bound_reg;
         REG_SYS_CFG: onchip_rd = sys_cfg_reg;
         default: ;
      endcase
      // Vector on acknowledge, register data on reads, else core data
      if (ack_cycle)
         dbus_next = vector_data;
      else if (rd_req)
         dbus_next = onchip_rd;
      else
         dbus_next = cpu_wdata;
      dbus_oe_n_next = (dir != DIR_OUT);
      capture_next   = (dir == DIR_IN);
      rom_cs_n_next  = !rom_sel;
      ram_cs_n_next  = !ram_sel;
      irq0_n_next    = !(serial_int_req || host_int_req);
      // Higher ranked source passes the chain only when idle
      if (sys_cfg_reg[CFG_CHAIN]) begin
         host_chain_next   = chain_sync_reg;
         serial_chain_next = chain_sync_reg && !host_int_pend;
      end else begin
         serial_chain_next = chain_sync_reg;
         host_chain_next   = chain_sync_reg && !serial_int_pend;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dbus_reg         <= 8'h00;
         dbus_oe_n_reg    <= 1'b1;
         capture_reg      <= 1'b0;
         rom_cs_n_reg     <= 1'b1;
         ram_cs_n_reg     <= 1'b1;
         irq0_n_reg       <= 1'b1;
         serial_chain_reg <= 1'b0;
         host_chain_reg   <= 1'b0;
      end else begin
         dbus_reg         <= dbus_next;
         dbus_oe_n_reg    <= dbus_oe_n_next;
         capture_reg      <= capture_next;
         rom_cs_n_reg     <= rom_cs_n_next;
         ram_cs_n_reg     <= ram_cs_n_next;
         irq0_n_reg       <= irq0_n_next;
         serial_chain_reg <= serial_chain_next;
         host_chain_reg   <= host_chain_next;
      end
   end

   assign dbus_out          = dbus_reg;
   assign dbus_oe_n         = dbus_oe_n_reg;
   assign dbus_capture      = capture_reg;
   assign rom_chip_select_n = rom_cs_n_reg;
   assign ram_chip_select_n = ram_cs_n_reg;
   assign irq0_n            = irq0_n_reg;
   assign serial_chain_in   = serial_chain_reg;
   assign host_chain_in     = host_chain_reg;

   // ----------------------------------------
   // Pin steering
   // ----------------------------------------
   logic [7:0] pc_out_reg, pc_out_next, pc_oe_reg, pc_oe_next;
   logic [7:0] pb_out_reg, pb_out_next, pb_oe_reg, pb_oe_next;
   logic [2:0] tri_out_reg, tri_out_next, tri_oe_reg, tri_oe_next;
   logic       port_en;
   logic [1:0] tri_code;

   // Parallel pins float while the port is disabled in host mode
   always_comb begin
      port_en  = !sys_cfg_reg[CFG_HOST];
      tri_code = sys_cfg_reg[CFG_TRI_HI:CFG_HOST];
      if (sys_cfg_reg[CFG_PORTC]) begin
         pc_out_next = port_c_out;
         pc_oe_next  = port_en ? port_c_oe_n : 8'hFF;
      end else begin
         pc_out_next = chan_a_out;
         pc_oe_next  = chan_a_oe_n;
      end
      if (sys_cfg_reg[CFG_PB75]) begin
         pb_out_next[7:5] = port_b_out[7:5];
         pb_oe_next[7:5]  = port_en ? port_b_oe_n[7:5] : 3'h7;
      end else begin
         // Receive and clear-to-send pins stay inputs
         pb_out_next[7:5] = {1'b0, async1_tx, 1'b0};
         pb_oe_next[7:5]  = 3'h5;
      end
      if (sys_cfg_reg[CFG_PB40]) begin
         pb_out_next[4:0] = port_b_out[4:0];
         pb_oe_next[4:0]  = port_en ? port_b_oe_n[4:0] : 5'h1F;
      end else begin
         pb_out_next[4:0] = async0_out;
         pb_oe_next[4:0]  = async0_oe_n;
      end
      unique case (tri_code)
         TRI_CHAN_B: begin
            tri_out_next = {chan_b_request_to_send_n,
                            chan_b_terminal_ready_req_n,
                            chan_b_wait_req_n};
            tri_oe_next  = 3'h0;
         end
         TRI_HOST: begin
            tri_out_next = {host_rx_ready_n, host_tx_ready_n,
                            host_interrupt};
            tri_oe_next  = 3'h0;
         end
         default: begin
            tri_out_next = {dma1_end_n, clocked_serial_tx,
                            clocked_serial_clock};
            tri_oe_next  = {2'h0, clocked_serial_clock_oe_n};
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pc_out_reg  <= 8'h00;
         pc_oe_reg   <= 8'hFF;
         pb_out_reg  <= 8'h00;
         pb_oe_reg   <= 8'hFF;
         tri_out_reg <= 3'h0;
         tri_oe_reg  <= 3'h7;
      end else begin
         pc_out_reg  <= pc_out_next;
         pc_oe_reg   <= pc_oe_next;
         pb_out_reg  <= pb_out_next;
         pb_oe_reg   <= pb_oe_next;
         tri_out_reg <= tri_out_next;
         tri_oe_reg  <= tri_oe_next;
      end
   end

   assign pc_pin_out   = pc_out_reg;
   assign pc_pin_oe_n  = pc_oe_reg;
   assign pb_pin_out   = pb_out_reg;
   assign pb_pin_oe_n  = pb_oe_reg;
   assign tri_pin_out  = tri_out_reg;
   assign tri_pin_oe_n = tri_oe_reg;

   assign emulator_direction_flag = sys_cfg_reg[CFG_EMU];
   assign chan_b_outputs_enable   = !sys_cfg_reg[CFG_HOST];
   assign parallel_port_enable    = !sys_cfg_reg[CFG_HOST];
   assign host_emul_enable        = sys_cfg_reg[CFG_HOST];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_rom_page;
      mem_cycle && !sys_cfg_reg[CFG_ROM_DIS] &&
      (cpu_addr[PAGE_HI:PAGE_LO] <= rom_upper_bound_reg);
   endsequence

   sequence s_ram_page;
      mem_cycle && (cpu_addr[PAGE_HI:PAGE_LO] >= ram_lower_bound_reg) &&
      (cpu_addr[PAGE_HI:PAGE_LO] <= ram_upper_bound_reg);
   endsequence

   a_rom_cs_range: assert property (s_rom_page |=> !rom_chip_select_n)
      else $error("ROM select missed in range");
   a_rom_cs_off: assert property (
      sys_cfg_reg[CFG_ROM_DIS] |=> rom_chip_select_n)
      else $error("ROM select asserted while disabled");
   a_ram_cs_range: assert property (s_ram_page ##0
      (sys_cfg_reg[CFG_ROM_DIS] ||
       cpu_addr[PAGE_HI:PAGE_LO] > rom_upper_bound_reg)
      |=> !ram_chip_select_n)
      else $error("RAM select missed in range");
   a_cs_exclusive: assert property (
      !(!rom_chip_select_n && !ram_chip_select_n))
      else $error("Both chip selects asserted");
   a_cs_non_mem: assert property (
      !mem_cycle |=> rom_chip_select_n && ram_chip_select_n)
      else $error("Chip select outside memory cycle");
   a_bound_reset: assert property ($rose(nrst) |->
      ram_upper_bound_reg == BOUND_RESET && ram_lower_bound_reg ==
      BOUND_RESET && rom_upper_bound_reg == BOUND_RESET)
      else $error("Bound registers not all ones after reset");
   a_cfg_write: assert property (io_wr && cpu_addr[7:0] == REG_SYS_CFG
      |=> sys_cfg_reg == $past(cpu_wdata))
      else $error("Config write not stored");
   a_irq_shared: assert property (
      (serial_int_req || host_int_req) |=> !irq0_n)
      else $error("Shared interrupt line not asserted");
   a_chain_order: assert property (sys_cfg_reg[CFG_CHAIN] &&
      host_int_pend |=> !serial_chain_in)
      else $error("Serial channel outranked host UART");
   a_portc_route: assert property (sys_cfg_reg[CFG_PORTC]
      |=> pc_pin_out == $past(port_c_out))
      else $error("Port C not routed to pins");
   a_emu_ack_drive: assert property (bus_master && ack_cycle &&
      chain_sync_reg && sys_cfg_reg[CFG_EMU] && !refresh
      |=> !dbus_oe_n ##1 1'b1)
      else $error("Vector not driven in emulator mode");
   a_idle_float: assert property (!io_req && !mem_req && !ack_cycle
      |=> dbus_oe_n)
      else $error("Data bus driven while idle");

endmodule

//--- ext_mem_model.sv
// External memory stand-in: reports which device the selects enable.
// Assumes active-low ROM and RAM selects from the block under test.
`timescale 1ns/1ns
module ext_mem_model (
   // Selects
   input  wire logic       rom_chip_select_n,
   input  wire logic       ram_chip_select_n,
   // Answering device, bit 0 ROM, bit 1 RAM
   output logic      [1:0] hit
);
   assign hit = {~ram_chip_select_n, ~rom_chip_select_n};
endmodule

//--- sys_config_chip_select_tb.sv
// Self-checking bench for configuration and chip-select logic.
// Assumes the partner only reports which memory device is selected.
`timescale 1ns/1ns
module sys_config_chip_select_tb;
   import sys_cfg_pkg::*;
   logic clk, nrst, io_req, mem_req, rd_req, wr_req, ack_cycle, refresh;
   logic bus_master, onchip_sel, chain_enable_in, async1_tx, dma1_end_n;
   logic serial_int_req, host_int_req, serial_int_pend, host_int_pend;
   logic clocked_serial_tx, clocked_serial_clock, clocked_serial_clock_oe_n;
   logic chan_b_request_to_send_n, chan_b_terminal_ready_req_n;
   logic chan_b_wait_req_n, host_rx_ready_n, host_tx_ready_n, host_interrupt;
   logic rd_hit, dbus_oe_n, dbus_capture, rom_chip_select_n, irq0_n;
   logic ram_chip_select_n, serial_chain_in, host_chain_in;
   logic emulator_direction_flag, chan_b_outputs_enable;
   logic parallel_port_enable, host_emul_enable;
   logic [19:0] cpu_addr;
   logic [7:0]  cpu_wdata, vector_data, rdata, dbus_out, port_c_out;
   logic [7:0]  port_c_oe_n, chan_a_out, chan_a_oe_n, pc_pin_out;
   logic [7:0]  pc_pin_oe_n, port_b_out, port_b_oe_n, pb_pin_out, pb_pin_oe_n;
   logic [4:0]  async0_out, async0_oe_n;
   logic [2:0]  tri_pin_out, tri_pin_oe_n;
   logic [1:0]  hit;
   logic [7:0]  bnd [3];
   logic [7:0]  cfg;
   int          n_errors = 0;
   int          n_compared = 0;
   int          cyc = 0;

   ext_mem_model mem_far (.rom_chip_select_n(rom_chip_select_n),
      .ram_chip_select_n(ram_chip_select_n), .hit(hit));
   sys_config_chip_select dut (.*);

   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   // Generous ceiling; the run needs a few hundred cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Random sources on every pin mux input and interrupt line
   task automatic shake();
      {vector_data, port_b_out, port_b_oe_n, port_c_out, port_c_oe_n,
       chan_a_out, chan_a_oe_n, async0_out, async0_oe_n, async1_tx,
       dma1_end_n, clocked_serial_tx, clocked_serial_clock,
       clocked_serial_clock_oe_n, chan_b_request_to_send_n,
       chan_b_terminal_ready_req_n, chan_b_wait_req_n, host_rx_ready_n,
       host_tx_ready_n, host_interrupt, chain_enable_in, onchip_sel,
       serial_int_req, host_int_req, serial_int_pend,
       host_int_pend} = 83'({$urandom, $urandom, $urandom});
   endtask
   // One I/O cycle; upper address bits are noise
   task automatic io(input logic wr, input logic [7:0] a, input logic [7:0] d);
      // Strobes stay up until the next task replaces them, never twice
      {io_req, mem_req, rd_req, wr_req, ack_cycle, refresh} =
         {2'b10, !wr, wr, 2'b00};
      cpu_addr = {12'($urandom), a};
      cpu_wdata = d;
      @(negedge clk);
      chk(8'(hit), 8'h00);
   endtask
   function automatic logic [7:0] reg_val(input logic [7:0] a);
      return a == REG_RAM_UB ? bnd[0] : a == REG_RAM_LB ? bnd[1] :
             a == REG_ROM_UB ? bnd[2] : a == REG_SYS_CFG ? cfg : 8'h00;
   endfunction
   function automatic logic [1:0] cs_exp(input logic [7:0] pg);
      cs_exp[0] = !cfg[3] && pg <= bnd[2];
      cs_exp[1] = !cs_exp[0] && pg <= bnd[0] && pg >= bnd[1];
   endfunction
   task automatic rchk(input logic [7:0] a);
      io(0, a, 8'h00);
      chk(rdata, reg_val(a));
      chk(8'(rd_hit), 8'(a inside {REG_RAM_UB, REG_RAM_LB, REG_ROM_UB,
         REG_SYS_CFG}));
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      io(1, a, d);
      if (a == REG_SYS_CFG) cfg = d;
      else bnd[a - REG_RAM_UB] = d;
      chk(8'({emulator_direction_flag, chan_b_outputs_enable,
         parallel_port_enable, host_emul_enable}),
         8'({cfg[4], !cfg[1], !cfg[1], cfg[1]}));
      rchk(a);
   endtask
   task automatic mem(input logic [7:0] pg);
      {io_req, mem_req, rd_req, wr_req, ack_cycle, refresh} = 6'h18;
      cpu_addr = {pg, 12'($urandom)};
      shake();
      @(negedge clk);
      chk(8'(hit), 8'(cs_exp(pg)));
      chk(8'({dbus_oe_n, dbus_capture}), 8'h03);
      chk(8'(irq0_n), 8'(!(serial_int_req || host_int_req)));
      if (!cfg[1]) chk(pc_pin_oe_n, cfg[7] ? port_c_oe_n : chan_a_oe_n);
   endtask
   // Kind k: io wr, io rd, mem wr, mem rd, ack, refresh, idle
   task automatic xfer(input int k);
      logic [5:0] kinds [7] = '{6'h24, 6'h28, 6'h14, 6'h18, 6'h22, 6'h11,
                                6'h00};
      logic [7:0] a;
      logic [7:0] d;
      int         e;
      shake();
      {io_req, mem_req, rd_req, wr_req, ack_cycle, refresh} = '0;
      bus_master = 1'($urandom);
      cpu_wdata = 8'($urandom);
      // Writes go to unmapped space so the model needs no update
      a = k == 0 ? 8'hF0 | 8'($urandom) : REG_RAM_UB + 8'($urandom % 10);
      cpu_addr = {8'($urandom), 4'h0, a};
      // Chain pin needs two edges through its synchroniser
      repeat (2) @(negedge clk);
      {io_req, mem_req, rd_req, wr_req, ack_cycle, refresh} = kinds[k];
      @(negedge clk);
      if (bus_master)
         e = k == 0 || k == 2 ? 2 : k == 3 ? 1 : k == 1 ?
             (!onchip_sel ? 1 : cfg[4] ? 2 : 0) : k == 4 ?
             (!chain_enable_in ? 1 : cfg[4] ? 2 : 0) : 0;
      else
         e = k == 0 ? int'(onchip_sel) : k == 3 ? 1 : k == 1 ?
             2 * onchip_sel : k == 4 ? 1 + onchip_sel : 0;
      d = k == 4 ? vector_data : k == 1 ? reg_val(a) : cpu_wdata;
      chk(8'({dbus_oe_n, dbus_capture}), 8'({e != 2, e == 1}));
      if (e == 2) chk(dbus_out, d);
      chk(8'(hit), k == 2 || k == 3 ?
          8'(cs_exp(cpu_addr[19:12])) : 8'h00);
      chk(8'({serial_chain_in, host_chain_in}),
          8'({chain_enable_in && !(cfg[0] && host_int_pend),
              chain_enable_in && !(!cfg[0] && serial_int_pend)}));
      chk(pc_pin_out, cfg[7] ? port_c_out : chan_a_out);
      chk(pb_pin_out, {cfg[6] ? port_b_out[7:5] : {1'b0, async1_tx, 1'b0},
          cfg[5] ? port_b_out[4:0] : async0_out});
      chk(pb_pin_oe_n, {cfg[6] ? (cfg[1] ? 3'h7 : port_b_oe_n[7:5]) : 3'h5,
          cfg[5] ? (cfg[1] ? 5'h1F : port_b_oe_n[4:0]) :
          async0_oe_n});
      chk(8'({tri_pin_out, tri_pin_oe_n}), 8'(!cfg[2] ? {dma1_end_n,
          clocked_serial_tx, clocked_serial_clock, 2'h0,
          clocked_serial_clock_oe_n} : cfg[1] ? {host_rx_ready_n,
          host_tx_ready_n, host_interrupt, 3'h0} : {chan_b_request_to_send_n,
          chan_b_terminal_ready_req_n, chan_b_wait_req_n, 3'h0}));
   endtask

   initial begin
      void'($urandom(33162));
      {nrst, io_req, mem_req, rd_req, wr_req, ack_cycle, refresh} = '0;
      bus_master = 1;
      cpu_addr = 0;
      cpu_wdata = 0;
      shake();
      bnd = '{BOUND_RESET, BOUND_RESET, BOUND_RESET};
      cfg = CFG_RESET;
      repeat (3) @(negedge clk);
      nrst = 1;
      foreach (bnd[i]) rchk(REG_RAM_UB + 8'(i));
      rchk(REG_SYS_CFG);
      rchk(8'hE9);
      mem(8'hFF);
      mem(8'h00);
      $display("test reset_values done");
      for (int i = 0; i < 80; i++) begin
         if (i % 10 == 0) wreg(REG_RAM_UB + 8'($urandom % 3), 8'($urandom));
         if (i % 5 == 0) wreg(REG_SYS_CFG, 8'($urandom));
         mem(8'($urandom));
         xfer(int'($urandom % 7));
      end
      $display("test random_decode done");
      tally_and_finish();
   end
endmodule
